/* gpp_defines.vh */
// Purpose: Constants for the four-port general-purpose pin block
// Assumes: Register index times four gives the byte address
// Notes: Definitions only
`ifndef GPP_DEFINES_VH
`define GPP_DEFINES_VH

`define GPP_ADDR_W 8
`define GPP_IDX_PORT_C_DATA 6'h02
`define GPP_IDX_PORT_D_DATA 6'h03
`define GPP_IDX_PORT_C_DIRECTION 6'h06
`define GPP_IDX_PORT_E_DATA 6'h08
`define GPP_IDX_PORT_F_DATA 6'h09
`define GPP_IDX_PORT_E_DIRECTION 6'h0C
`define GPP_IDX_PORT_F_DIRECTION 6'h0D

`define GPP_C_W 7
`define GPP_D_W 7
`define GPP_E_W 8
`define GPP_F_W 6
`define GPP_PIN_W 28

`define GPP_DIR_RESET_C 7'h00
`define GPP_DIR_RESET_E 8'h00
`define GPP_DIR_RESET_F 6'h00

`define GPP_RESP_OKAY 2'h0
`define GPP_RESP_SLVERR 2'h2

`endif

/* gpp_sync.v */
// Purpose: Two-stage synchroniser for a bundle of pin levels
// Assumes: Each bit is an independent level
// Notes: Only the second stage may be read by other logic
module gpp_sync #(
  parameter W = 28
) (
  input wire clk_i,
  input wire srst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

/* gpp_pindrv.v */
// Purpose: Registered pin driver for one bidirectional port
// Assumes: Peripheral override signals come from logic on the same clock
// Notes: Output enable is active low; reset releases every pin
module gpp_pindrv #(
  parameter W = 8
) (
  input wire clk_i,
  input wire srst_i,
  input wire [W-1:0] latch_i,
  input wire [W-1:0] dir_i,
  input wire [W-1:0] alt_en_i,
  input wire [W-1:0] alt_out_i,
  input wire [W-1:0] alt_drive_i,
  output wire [W-1:0] pin_out_o,
  output wire [W-1:0] pin_oe_n_o
);
  reg [W-1:0] out_q;
  reg [W-1:0] oe_n_q;
  genvar i;

  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (srst_i) begin
          out_q[i] <= 1'b0;
          oe_n_q[i] <= 1'b1;
        end else if (alt_en_i[i]) begin
          // A peripheral owning the pin decides its direction
          out_q[i] <= alt_out_i[i];
          oe_n_q[i] <= ~alt_drive_i[i];
        end else begin
          out_q[i] <= latch_i[i];
          oe_n_q[i] <= ~dir_i[i];
        end
      end
    end
  endgenerate

  assign pin_out_o = out_q;
  assign pin_oe_n_o = oe_n_q;
endmodule

/* gpp_ports.v */
// Purpose: Ports C, D, E and F with data latches, and direction registers for C, E and F, behind AXI4-Lite
// Assumes: One clock; pins arrive asynchronously; peripheral override inputs are on CLK_I
// Notes: Data latches carry no reset, so they hold their value across SRST_I
//
// Design decision made here: the AXI4-Lite slave port.
`include "gpp_defines.vh"

module gpp_ports (
  input wire CLK_I,
  input wire SRST_I,
  input wire [`GPP_ADDR_W-1:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output wire [1:0] BRESP_O,
  output wire BVALID_O,
  input wire BREADY_I,
  input wire [`GPP_ADDR_W-1:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output wire [31:0] RDATA_O,
  output wire [1:0] RRESP_O,
  output wire RVALID_O,
  input wire RREADY_I,
  input wire [6:0] PC_PIN_I,
  output wire [6:0] PC_PIN_O,
  output wire [6:0] PC_PIN_OE_N_O,
  input wire [6:0] PD_PIN_I,
  output wire [6:0] PD_LEVEL_O,
  input wire [7:0] PE_PIN_I,
  output wire [7:0] PE_PIN_O,
  output wire [7:0] PE_PIN_OE_N_O,
  input wire [7:0] PE_ALT_EN_I,
  input wire [7:0] PE_ALT_OUT_I,
  input wire [7:0] PE_ALT_DRIVE_I,
  input wire [5:0] PF_PIN_I,
  output wire [5:0] PF_PIN_O,
  output wire [5:0] PF_PIN_OE_N_O,
  input wire [5:0] PF_ALT_EN_I,
  input wire [5:0] PF_ALT_OUT_I,
  input wire [5:0] PF_ALT_DRIVE_I
);
  // Register state
  reg [6:0] port_c_latch_q;
  reg [6:0] port_d_latch_q;
  reg [7:0] port_e_latch_q;
  reg [5:0] port_f_latch_q;
  reg [6:0] port_c_direction_q;
  reg [7:0] port_e_direction_q;
  reg [5:0] port_f_direction_q;

  // Write channel state
  reg aw_held_q;
  reg aw_held_d;
  reg [5:0] aw_idx_q;
  reg w_held_q;
  reg w_held_d;
  reg [7:0] w_byte_q;
  reg w_lane_q;
  reg awready_q;
  reg wready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;

  // Read channel state, plus the read and write decode results
  reg arready_q;
  reg rvalid_q;
  reg [31:0] rdata_q;
  reg [1:0] rresp_q;
  reg [7:0] rd_byte_d;
  reg rd_hit_d;
  reg wr_hit_d;

  wire [`GPP_PIN_W-1:0] pins_sync;
  wire [6:0] pc_level;
  wire [6:0] pd_level;
  wire [7:0] pe_level;
  wire [5:0] pf_level;
  reg [6:0] pd_level_q;

  wire aw_take;
  wire w_take;
  wire do_write;
  wire ar_take;
  wire [5:0] ar_idx;

  // Pins are asynchronous to CLK_I
  // Pin reads therefore lag the pins by two edges of CLK_I
  gpp_sync #(
    .W(`GPP_PIN_W)
  ) u_sync (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .async_i({PF_PIN_I, PE_PIN_I, PD_PIN_I, PC_PIN_I}),
    .sync_o(pins_sync)
  );

  assign pc_level = pins_sync[6:0];
  assign pd_level = pins_sync[13:7];
  assign pe_level = pins_sync[21:14];
  assign pf_level = pins_sync[27:22];

  // Write address and data may arrive in either order
  assign aw_take = AWVALID_I & awready_q;
  assign w_take = WVALID_I & wready_q;
  // Holding the update until B drains keeps one write in flight
  assign do_write = aw_held_q & w_held_q & ~bvalid_q;

  always @* begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
    end else begin
      if (aw_take) begin
        aw_held_d = 1'b1;
      end
      if (w_take) begin
        w_held_d = 1'b1;
      end
    end
  end

  always @* begin
    case (aw_idx_q)
      `GPP_IDX_PORT_C_DATA: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_D_DATA: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_C_DIRECTION: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_E_DATA: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_F_DATA: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_E_DIRECTION: wr_hit_d = 1'b1;
      `GPP_IDX_PORT_F_DIRECTION: wr_hit_d = 1'b1;
      default: wr_hit_d = 1'b0;
    endcase
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 6'h00;
      w_byte_q <= 8'h00;
      w_lane_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `GPP_RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awready_q <= ~aw_held_d;
      wready_q <= ~w_held_d;
      if (aw_take) begin
        aw_idx_q <= AWADDR_I[`GPP_ADDR_W-1:2];
      end
      if (w_take) begin
        w_byte_q <= WDATA_I[7:0];
        w_lane_q <= WSTRB_I[0];
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit_d ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
      end else if (bvalid_q & BREADY_I) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Latches are written regardless of direction and have no reset
  always @(posedge CLK_I) begin
    if (do_write & w_lane_q) begin
      case (aw_idx_q)
        `GPP_IDX_PORT_C_DATA: port_c_latch_q <= w_byte_q[6:0];
        // Port D latch is write-only; port D reads always show the pins
        `GPP_IDX_PORT_D_DATA: port_d_latch_q <= w_byte_q[6:0];
        `GPP_IDX_PORT_E_DATA: port_e_latch_q <= w_byte_q;
        `GPP_IDX_PORT_F_DATA: port_f_latch_q <= w_byte_q[5:0];
        default: port_c_latch_q <= port_c_latch_q;
      endcase
    end
  end

  // Direction bits clear on reset so every pin not owned by a peripheral starts as an input
  // Bits above a port's width are dropped, so they read back as zero
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      port_c_direction_q <= `GPP_DIR_RESET_C;
      port_e_direction_q <= `GPP_DIR_RESET_E;
      port_f_direction_q <= `GPP_DIR_RESET_F;
    end else if (do_write & w_lane_q) begin
      case (aw_idx_q)
        `GPP_IDX_PORT_C_DIRECTION: port_c_direction_q <= w_byte_q[6:0];
        `GPP_IDX_PORT_E_DIRECTION: port_e_direction_q <= w_byte_q;
        `GPP_IDX_PORT_F_DIRECTION: port_f_direction_q <= w_byte_q[5:0];
        default: port_c_direction_q <= port_c_direction_q;
      endcase
    end
  end

  // Read path: one read outstanding at a time
  // ARREADY returns at the handshake edge, so back-to-back reads cost one idle cycle
  assign ar_take = ARVALID_I & arready_q;
  assign ar_idx = ARADDR_I[`GPP_ADDR_W-1:2];

  always @* begin
    rd_byte_d = 8'h00;
    rd_hit_d = 1'b1;
    case (ar_idx)
      `GPP_IDX_PORT_C_DATA: begin
        // Direction picks latch or pin per bit
        rd_byte_d = {1'b0, (port_c_direction_q & port_c_latch_q) | (~port_c_direction_q & pc_level)};
      end
      `GPP_IDX_PORT_D_DATA: begin
        rd_byte_d = {1'b0, pd_level};
      end
      `GPP_IDX_PORT_C_DIRECTION: begin
        rd_byte_d = {1'b0, port_c_direction_q};
      end
      `GPP_IDX_PORT_E_DATA: begin
        // Selection holds even when a timer owns the pin
        rd_byte_d = (port_e_direction_q & port_e_latch_q) | (~port_e_direction_q & pe_level);
      end
      `GPP_IDX_PORT_F_DATA: begin
        // Selection holds even when SPI or serial owns the pin
        rd_byte_d = {2'b00, (port_f_direction_q & port_f_latch_q) | (~port_f_direction_q & pf_level)};
      end
      `GPP_IDX_PORT_E_DIRECTION: begin
        rd_byte_d = port_e_direction_q;
      end
      `GPP_IDX_PORT_F_DIRECTION: begin
        rd_byte_d = {2'b00, port_f_direction_q};
      end
      default: begin
        rd_byte_d = 8'h00;
        rd_hit_d = 1'b0;
      end
    endcase
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `GPP_RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_byte_d};
      rresp_q <= rd_hit_d ? `GPP_RESP_OKAY : `GPP_RESP_SLVERR;
    end else if (rvalid_q) begin
      if (RREADY_I) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end else begin
      arready_q <= 1'b1;
    end
  end

  // Port D has no drivers; its level is passed on to the motor PWM logic
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      pd_level_q <= 7'h00;
    end else begin
      pd_level_q <= pd_level;
    end
  end

  // Registered drivers cost one cycle but keep the pins free of decode glitches
  // Port C has no peripheral override in this block
  gpp_pindrv #(
    .W(`GPP_C_W)
  ) u_drv_c (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .latch_i(port_c_latch_q),
    .dir_i(port_c_direction_q),
    .alt_en_i(7'h00),
    .alt_out_i(7'h00),
    .alt_drive_i(7'h00),
    .pin_out_o(PC_PIN_O),
    .pin_oe_n_o(PC_PIN_OE_N_O)
  );

  // Timer override of port E direction
  gpp_pindrv #(
    .W(`GPP_E_W)
  ) u_drv_e (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .latch_i(port_e_latch_q),
    .dir_i(port_e_direction_q),
    .alt_en_i(PE_ALT_EN_I),
    .alt_out_i(PE_ALT_OUT_I),
    .alt_drive_i(PE_ALT_DRIVE_I),
    .pin_out_o(PE_PIN_O),
    .pin_oe_n_o(PE_PIN_OE_N_O)
  );

  // SPI or serial override of port F direction
  gpp_pindrv #(
    .W(`GPP_F_W)
  ) u_drv_f (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .latch_i(port_f_latch_q),
    .dir_i(port_f_direction_q),
    .alt_en_i(PF_ALT_EN_I),
    .alt_out_i(PF_ALT_OUT_I),
    .alt_drive_i(PF_ALT_DRIVE_I),
    .pin_out_o(PF_PIN_O),
    .pin_oe_n_o(PF_PIN_OE_N_O)
  );

  assign AWREADY_O = awready_q;
  assign WREADY_O = wready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RDATA_O = rdata_q;
  assign RRESP_O = rresp_q;
  assign PD_LEVEL_O = pd_level_q;
endmodule

/* gpp_pin_model.sv */
// Purpose: Pin-level model of whatever sits on the far side of one port
// Assumes: External source drives every pin that the block leaves undriven
// Notes: No pull resistors, so an undriven pin shows only the external level
module gpp_pin_model #(
  parameter W = 8
) (
  input wire [W-1:0] ext_i,
  input wire [W-1:0] out_i,
  input wire [W-1:0] oe_n_i,
  output wire [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven bits loop back the block's own value; released bits follow the outside
  assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_i);
endmodule

/* gpp_ports_properties.sv */
// Purpose: Bus and pin timing checks for gpp_ports
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every gpp_ports instance
module gpp_ports_props (
  input wire CLK_I,
  input wire SRST_I,
  input wire AWVALID_I,
  input wire AWREADY_O,
  input wire WVALID_I,
  input wire WREADY_O,
  input wire [1:0] BRESP_O,
  input wire BVALID_O,
  input wire BREADY_I,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire [31:0] RDATA_O,
  input wire RVALID_O,
  input wire RREADY_I,
  input wire [6:0] PC_PIN_OE_N_O,
  input wire [7:0] PE_PIN_OE_N_O,
  input wire [7:0] PE_ALT_EN_I,
  input wire [7:0] PE_ALT_DRIVE_I,
  input wire [5:0] PF_PIN_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  a_reset_pins_off: assert property ($fell(SRST_I) |->
    (&PC_PIN_OE_N_O) && (&PE_PIN_OE_N_O) && (&PF_PIN_OE_N_O)) else $error("pin driven after reset");
  a_read_one_cycle: assert property (ARVALID_I && ARREADY_O |=> RVALID_O) else $error("read answer late");
  a_read_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");
  a_read_upper_zero: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_write_two_cycles: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write answer late");
  a_write_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write response dropped");
  a_addr_refused: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O) else $error("second address taken");
  a_read_blocked: assert property (RVALID_O |-> !ARREADY_O) else $error("read taken while answer pending");
  a_timer_owns_e: assert property (PE_ALT_EN_I == 8'hFF |=> PE_PIN_OE_N_O == ~$past(PE_ALT_DRIVE_I))
    else $error("timer drive ignored");
endmodule

bind gpp_ports gpp_ports_props gpp_ports_props_inst (.*);

/* gpp_ports_bench.sv */
// Purpose: Register and pin tests for gpp_ports over AXI4-Lite
// Assumes: Byte address is four times the register index
// Notes: Pin levels are set before writes so the synchroniser has settled
module gpp_ports_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ad_c = 8'h08;
  localparam logic [7:0] ad_d = 8'h0C;
  localparam logic [7:0] ad_cdir = 8'h18;
  localparam logic [7:0] ad_e = 8'h20;
  localparam logic [7:0] ad_f = 8'h24;
  localparam logic [7:0] ad_edir = 8'h30;
  localparam logic [7:0] ad_fdir = 8'h34;
  logic CLK_I = 1'b0;
  logic SRST_I = 1'b1;
  logic AWVALID_I = 1'b0;
  logic WVALID_I = 1'b0;
  logic BREADY_I = 1'b0;
  logic ARVALID_I = 1'b0;
  logic RREADY_I = 1'b0;
  logic [7:0] AWADDR_I = 8'h00;
  logic [7:0] ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h00000000;
  logic [3:0] WSTRB_I = 4'hF;
  logic [6:0] PD_PIN_I = 7'h2A;
  logic [7:0] PE_ALT_EN_I = 8'h00;
  logic [7:0] PE_ALT_OUT_I = 8'h00;
  logic [7:0] PE_ALT_DRIVE_I = 8'h00;
  logic [5:0] PF_ALT_EN_I = 6'h00;
  logic [5:0] PF_ALT_OUT_I = 6'h00;
  logic [5:0] PF_ALT_DRIVE_I = 6'h00;
  logic [6:0] pc_x = 7'h55;
  logic [7:0] pe_x = 8'h3C;
  logic [5:0] pf_x = 6'h15;
  wire AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  wire [1:0] BRESP_O, RRESP_O;
  wire [31:0] RDATA_O;
  wire [6:0] PC_PIN_I, PC_PIN_O, PC_PIN_OE_N_O, PD_LEVEL_O;
  wire [7:0] PE_PIN_I, PE_PIN_O, PE_PIN_OE_N_O;
  wire [5:0] PF_PIN_I, PF_PIN_O, PF_PIN_OE_N_O;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  // Cycles the master waits before raising BREADY or RREADY
  int lag = 0;

  gpp_ports gpp_ports_inst (.*);
  gpp_pin_model #(.W(7)) gpp_pin_model_c_inst (.ext_i(pc_x), .out_i(PC_PIN_O), .oe_n_i(PC_PIN_OE_N_O), .pin_o(PC_PIN_I));
  gpp_pin_model #(.W(8)) gpp_pin_model_e_inst (.ext_i(pe_x), .out_i(PE_PIN_O), .oe_n_i(PE_PIN_OE_N_O), .pin_o(PE_PIN_I));
  gpp_pin_model #(.W(6)) gpp_pin_model_f_inst (.ext_i(pf_x), .out_i(PF_PIN_O), .oe_n_i(PF_PIN_OE_N_O), .pin_o(PF_PIN_I));

  always #10 CLK_I = ~CLK_I;

  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("Checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_sim;
    end
  end

  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ap;
    logic wp;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= {24'h000000, d};
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= (lag == 0);
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge CLK_I);
      if (AWREADY_O === 1'b1) ap = 1'b0;
      if (WREADY_O === 1'b1) wp = 1'b0;
      AWVALID_I <= ap;
      WVALID_I <= wp;
    end
    repeat (lag) @(posedge CLK_I);
    BREADY_I <= 1'b1;
    do @(posedge CLK_I); while (BVALID_O !== 1'b1);
    BREADY_I <= 1'b0;
    chk(BRESP_O, er, "bresp");
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= (lag == 0);
    do @(posedge CLK_I); while (ARREADY_O !== 1'b1);
    ARVALID_I <= 1'b0;
    repeat (lag) @(posedge CLK_I);
    RREADY_I <= 1'b1;
    do @(posedge CLK_I); while (RVALID_O !== 1'b1);
    RREADY_I <= 1'b0;
    chk(RDATA_O, {24'h000000, e}, "rdata");
    chk(RRESP_O, er, "rresp");
  endtask

  initial begin
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    rd(ad_cdir, 8'h00, 2'h0);
    rd(ad_edir, 8'h00, 2'h0);
    rd(ad_fdir, 8'h00, 2'h0);
    $display("test reset values done");
    // Latch loaded before any direction bit is set, as software should
    wr(ad_c, 8'hFF, 2'h0);
    rd(ad_c, 8'h55, 2'h0);
    chk(PC_PIN_OE_N_O, 7'h7F, "c_oe_n");
    wr(ad_cdir, 8'h8F, 2'h0);
    rd(ad_cdir, 8'h0F, 2'h0);
    @(posedge CLK_I);
    chk(PC_PIN_OE_N_O, 7'h70, "c_oe_n");
    chk(PC_PIN_O, 7'h7F, "c_out");
    rd(ad_c, 8'h5F, 2'h0);
    $display("test port c done");
    @(posedge CLK_I);
    SRST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    rd(ad_cdir, 8'h00, 2'h0);
    wr(ad_cdir, 8'h7F, 2'h0);
    rd(ad_c, 8'h7F, 2'h0);
    $display("test reset mid-run done");
    wr(ad_d, 8'h12, 2'h0);
    rd(ad_d, 8'h2A, 2'h0);
    chk(PD_LEVEL_O, 7'h2A, "d_level");
    $display("test port d done");
    PE_ALT_EN_I <= 8'hFF;
    PE_ALT_DRIVE_I <= 8'h0F;
    PE_ALT_OUT_I <= 8'h06;
    wr(ad_e, 8'hA5, 2'h0);
    wr(ad_edir, 8'hF0, 2'h0);
    @(posedge CLK_I);
    chk(PE_PIN_OE_N_O, 8'hF0, "e_oe_n");
    chk(PE_PIN_O, 8'h06, "e_out");
    rd(ad_e, 8'hA6, 2'h0);
    PE_ALT_EN_I <= 8'h00;
    repeat (2) @(posedge CLK_I);
    chk(PE_PIN_OE_N_O, 8'h0F, "e_oe_n");
    chk(PE_PIN_O, 8'hA5, "e_out");
    rd(ad_edir, 8'hF0, 2'h0);
    $display("test port e done");
    PF_ALT_EN_I <= 6'h30;
    wr(ad_f, 8'hEA, 2'h0);
    wr(ad_fdir, 8'hFF, 2'h0);
    @(posedge CLK_I);
    chk(PF_PIN_OE_N_O, 6'h30, "f_oe_n");
    chk(PF_PIN_O, 6'h0A, "f_out");
    rd(ad_f, 8'h2A, 2'h0);
    // Late ready from here on, so the response hold checks see a stall
    lag = 3;
    rd(ad_fdir, 8'h3F, 2'h0);
    $display("test port f done");
    @(posedge CLK_I);
    SRST_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    SRST_I <= 1'b0;
    rd(ad_fdir, 8'h00, 2'h0);
    wr(ad_fdir, 8'h3F, 2'h0);
    rd(ad_f, 8'h2A, 2'h0);
    $display("test port f reset done");
    wr(8'h04, 8'h11, 2'h2);
    rd(8'h04, 8'h00, 2'h2);
    $display("test unmapped done");
    end_sim;
  end
endmodule
